/* wmc_pkg.sv */
// Constants shared by the watchdog mode and clock select block
// Summary of operation
// - Halt-activity bit 1 keeps watchdog counting
// - Stop-activity bit 1 keeps watchdog counting
// - Stop mode clocks chain from RC oscillator
// - Stop-activity plus clock-source: crystal drives watchdog
// - Clock-source bit picks crystal or RC clock
// - Three upper mode bits do nothing
// - Supply below threshold holds global reset
// - Mode writes accepted only in early window
// - Retriggerable one-shot, disabled once started only by reset_n, low supply or its own timeout
// - Timeout taps 256/512/1024/4096, reset code 01
package wmc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] WMC_MODE_ADDR = 8'h0F;
  localparam logic [7:0] WMC_STATUS_ADDR = 8'h00;
  // ==========================================================
  // Mode register field positions
  localparam int WMC_TAP_LSB = 0;
  localparam int WMC_TAP_MSB = 1;
  localparam int WMC_HALT_BIT = 2;
  localparam int WMC_STOP_BIT = 3;
  localparam int WMC_SRC_BIT = 4;
  localparam int WMC_MODE_BITS = 5;
  // Mode register value after reset: taps 01, halt 1, stop 1, src 0
  localparam logic [4:0] WMC_MODE_RESET = 5'h0D;
  // ==========================================================
  // Cycle counts: window in crystal cycles, taps in ticks of the selected chain clock
  localparam int WMC_WINDOW_CYCLES = 128;
  localparam int WMC_TAP0_CYCLES = 256;
  localparam int WMC_TAP1_CYCLES = 512;
  localparam int WMC_TAP2_CYCLES = 1024;
  localparam int WMC_TAP3_CYCLES = 4096;
  localparam int WMC_COUNT_WIDTH = 13;
  localparam int WMC_SYNC_STAGES = 2;
endpackage : wmc_pkg

/* wmc_pin_sync.sv */
// Two-stage pin synchroniser with rising-edge pulse
`timescale 1ns/10ps
`default_nettype none
module wmc_pin_sync
  import wmc_pkg::*;
(
  // Clock and reset
  input wire logic sysClk,
  input wire logic rstN,
  input wire logic clkEn,
  // Asynchronous pin
  input wire logic pinIn,
  // Synchronised outputs
  output logic level,
  output logic rise
);
  // Shift chain; stage 0 is read only by stage 1
  logic [WMC_SYNC_STAGES-1:0] chain;
  // Delayed copy for edge detection
  logic levelDly;

  // ==========================================================
  // Synchroniser chain
  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      chain <= '0;
      levelDly <= 1'b0;
    end else if (clkEn) begin
      chain <= {chain[WMC_SYNC_STAGES-2:0], pinIn};
      levelDly <= chain[WMC_SYNC_STAGES-1];
    end
  end

  // Outputs from the last stage only
  assign level = chain[WMC_SYNC_STAGES-1];
  assign rise = clkEn & chain[WMC_SYNC_STAGES-1] & ~levelDly;
endmodule : wmc_pin_sync
`default_nettype wire

/* wmc_watchdog_mode_clock_select.sv */
// Watchdog mode register, clock source select and counter chain
`timescale 1ns/10ps
`default_nettype none
module wmc_watchdog_mode_clock_select
  import wmc_pkg::*;
(
  // Clock, enable and reset
  input wire logic sys_clk,
  input wire logic clkEn,
  input wire logic reset_n,
  // Oscillator pins
  input wire logic crystal_input_pin,
  input wire logic rcOscPin,
  // Supply comparator, high while supply below trip point
  input wire logic low_voltage_trip_point,
  // Processor status, same clock domain
  input wire logic haltMode,
  input wire logic stopMode,
  input wire logic stopRecovery,
  input wire logic watchdogInstr,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Reset outputs
  output logic globalReset,
  output logic watchdogReset
);
  // ==========================================================
  // Internal state
  logic rstSync1; // Reset release stage one
  logic rstN; // Synchronised reset
  logic crystalRise; // Crystal tick
  logic rcRise; // RC oscillator tick
  logic supplyLow; // Synchronised comparator level
  logic [4:0] watchdog_mode_control; // Stored mode bits
  logic windowOpen; // Mode writes allowed
  logic [7:0] windowCnt; // Crystal cycles since restart
  logic watchdogEnabled; // Started by first instruction
  logic [WMC_COUNT_WIDTH-1:0] watchdog_counter; // Timeout counter
  logic [WMC_COUNT_WIDTH-1:0] terminal; // Selected terminal count
  logic useCrystal; // Chain clocked by crystal
  logic chainTick; // Selected tick
  logic suspended; // Counting held in standby
  logic fire; // Terminal count reached
  logic [7:0] next_rdData; // Read mux result

  // ==========================================================
  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync1 <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstN <= rstSync1;
    end
  end

  // ==========================================================
  // Pin synchronisers
  wmc_pin_sync uCrystal (
    .sysClk(sys_clk),
    .rstN(rstN),
    .clkEn(clkEn),
    .pinIn(crystal_input_pin),
    .level(),
    .rise(crystalRise)
  );

  wmc_pin_sync uRc (
    .sysClk(sys_clk),
    .rstN(rstN),
    .clkEn(clkEn),
    .pinIn(rcOscPin),
    .level(),
    .rise(rcRise)
  );

  wmc_pin_sync uSupply (
    .sysClk(sys_clk),
    .rstN(rstN),
    .clkEn(clkEn),
    .pinIn(low_voltage_trip_point),
    .level(supplyLow),
    .rise()
  );

  // ==========================================================
  // Clock source and suspension
  always_comb begin
    // Stop mode: RC unless stop-activity and crystal source both set
    if (stopMode) begin
      useCrystal = watchdog_mode_control[WMC_STOP_BIT] &
                   watchdog_mode_control[WMC_SRC_BIT];
    end else begin
      useCrystal = watchdog_mode_control[WMC_SRC_BIT];
    end
    chainTick = useCrystal ? crystalRise : rcRise;
    // Activity bits gate counting in standby
    suspended = (haltMode & ~watchdog_mode_control[WMC_HALT_BIT])
              | (stopMode & ~watchdog_mode_control[WMC_STOP_BIT]);
  end

  // Terminal count from the tap code
  always_comb begin
    unique case (watchdog_mode_control[WMC_TAP_MSB:WMC_TAP_LSB])
      2'h0: terminal = WMC_COUNT_WIDTH'(WMC_TAP0_CYCLES - 1);
      2'h1: terminal = WMC_COUNT_WIDTH'(WMC_TAP1_CYCLES - 1);
      2'h2: terminal = WMC_COUNT_WIDTH'(WMC_TAP2_CYCLES - 1);
      2'h3: terminal = WMC_COUNT_WIDTH'(WMC_TAP3_CYCLES - 1);
    endcase
  end

  // Fires on the tick taken while the counter already sits at terminal count
  assign fire = clkEn & watchdogEnabled & ~suspended & chainTick &
                (watchdog_counter == terminal);

  // ==========================================================
  // Write window after reset, watchdog reset or stop recovery
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      windowCnt <= 8'h00;
      windowOpen <= 1'b1;
    end else if (clkEn) begin
      if (supplyLow || fire || stopRecovery) begin
        // Restart the window
        windowCnt <= 8'h00;
        windowOpen <= 1'b1;
      end else if (windowOpen && crystalRise) begin
        windowCnt <= windowCnt + 8'h01;
        if (windowCnt == 8'(WMC_WINDOW_CYCLES - 1)) begin
          windowOpen <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Mode register, write only
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      watchdog_mode_control <= WMC_MODE_RESET;
    end else if (clkEn) begin
      if (supplyLow || fire) begin
        // Device reset restores defaults
        watchdog_mode_control <= WMC_MODE_RESET;
      end else if (regWrite && regAddr == WMC_MODE_ADDR && windowOpen) begin
        // Upper three bits are dropped
        watchdog_mode_control <= regWrData[WMC_MODE_BITS-1:0];
      end
    end
  end

  // ==========================================================
  // Watchdog enable, one-shot counter
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      watchdogEnabled <= 1'b0;
      watchdog_counter <= '0;
    end else if (clkEn) begin
      if (supplyLow || fire) begin
        // Reset ends the run
        watchdogEnabled <= 1'b0;
        watchdog_counter <= '0;
      end else if (watchdogInstr) begin
        // First use starts, later uses refresh
        watchdogEnabled <= 1'b1;
        watchdog_counter <= '0;
      end else if (watchdogEnabled && !suspended && chainTick) begin
        watchdog_counter <= watchdog_counter + 1'b1;
      end
      // Suspended: counter simply holds its value
    end
  end

  // ==========================================================
  // Reset outputs
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      globalReset <= 1'b1;
      watchdogReset <= 1'b0;
    end else if (clkEn) begin
      globalReset <= supplyLow | fire;
      watchdogReset <= fire;
    end
  end

  // ==========================================================
  // Read path: mode register never reads back
  always_comb begin
    next_rdData = 8'h00;
    if (regAddr == WMC_STATUS_ADDR) begin
      next_rdData = {5'h00, useCrystal, windowOpen, watchdogEnabled};
    end
  end

  // Read data one cycle after strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      regRdData <= 8'h00;
    end else if (clkEn) begin
      regRdData <= regRead ? next_rdData : 8'h00;
    end
  end
endmodule : wmc_watchdog_mode_clock_select
`default_nettype wire

/* wmc_props.sv */
// Property checker for the watchdog mode block
`timescale 1ns/10ps
`default_nettype none
module wmc_props
  import wmc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // Watched inputs
  input wire logic low_voltage_trip_point,
  input wire logic watchdogInstr,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  // Watched outputs
  input wire logic [7:0] regRdData,
  input wire logic globalReset,
  input wire logic watchdogReset
);
  // ==========
  // Single clock domain
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Watchdog started since last device reset
  logic armed;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) armed <= 1'h0;
    else if (clkEn && watchdogInstr) armed <= 1'h1;
    else if (globalReset) armed <= 1'h0;
  end
  // ==========
  // Assertions
  fire_pulse_a: assert property (watchdogReset |=> !watchdogReset[*8])
    else $error("fire pulse repeats");
  fire_resets_a: assert property (watchdogReset |-> globalReset)
    else $error("fire without device reset");
  fire_armed_a: assert property (watchdogReset |-> armed)
    else $error("fire while never started");
  read_idle_a: assert property (clkEn && !regRead |=>
    regRdData == 8'h00) else $error("read data without read");
  mode_hidden_a: assert property (regRead && regAddr == WMC_MODE_ADDR
    |=> regRdData == 8'h00) else $error("mode register readable");
  start_seen_a: assert property (clkEn && watchdogInstr ##1
    clkEn && !globalReset ##1 clkEn && !globalReset && regRead &&
    regAddr == WMC_STATUS_ADDR |=> regRdData[0])
    else $error("start not shown in status");
  low_hold_a: assert property (
    low_voltage_trip_point[*5] |-> globalReset) else $error("low supply");
  low_quiet_a: assert property (
    low_voltage_trip_point[*5] |-> !watchdogReset) else $error("fire in reset");
  // Main scenarios reached
  cover property (watchdogReset);
  cover property (low_voltage_trip_point[*5]);
  cover property (regRead ##1 regRdData != 8'h00);
endmodule : wmc_props
bind wmc_watchdog_mode_clock_select wmc_props u_props (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .clkEn(clkEn),
  .low_voltage_trip_point(low_voltage_trip_point),
  .watchdogInstr(watchdogInstr),
  .regAddr(regAddr),
  .regRead(regRead),
  .regRdData(regRdData),
  .globalReset(globalReset),
  .watchdogReset(watchdogReset)
);
`default_nettype wire

/* test_watchdog_mode_clock_select.sv */
// Self-checking bench for the watchdog mode block
`timescale 1ns/10ps
`default_nettype none
module test_watchdog_mode_clock_select;
  import wmc_pkg::*;
  // ==========
  // Bench signals
  logic sys_clk = 1'h0, reset_n = 1'h0, crystal_input_pin = 1'h0;
  logic rcOscPin = 1'h0, low_voltage_trip_point = 1'h0;
  logic haltMode = 1'h0, stopMode = 1'h0, watchdogInstr = 1'h0;
  logic regWrite = 1'h0, regRead = 1'h0, globalReset, watchdogReset;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [7:0] fires = 8'h00;
  logic clkEn = 1'h1, stopRecovery = 1'h0;
  int n_mismatch = 0, samples_checked = 0;
  // Clock
  always #25 sys_clk = ~sys_clk;
  // Count fire pulses mid-cycle
  always @(negedge sys_clk)
    if (watchdogReset === 1'h1) fires <= fires + 8'h01;
  wmc_watchdog_mode_clock_select u_dut (
    .sys_clk(sys_clk),
    .clkEn(clkEn),
    .reset_n(reset_n),
    .crystal_input_pin(crystal_input_pin),
    .rcOscPin(rcOscPin),
    .low_voltage_trip_point(low_voltage_trip_point),
    .haltMode(haltMode),
    .stopMode(stopMode),
    .stopRecovery(stopRecovery),
    .watchdogInstr(watchdogInstr),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdData(regRdData),
    .globalReset(globalReset),
    .watchdogReset(watchdogReset)
  );
  // ==========
  // Tasks
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge sys_clk) regWrite <= 1'h0;
    @(posedge sys_clk);
  endtask : wr
  // Read data stand in the cycle after the strobe; sampled at its end
  task rd(input logic [7:0] a, input logic [7:0] e);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge sys_clk) regRead <= 1'h0;
    @(posedge sys_clk) chk(regRdData, e);
  endtask : rd
  task ins();
    watchdogInstr <= 1'h1;
    @(posedge sys_clk) watchdogInstr <= 1'h0;
    @(posedge sys_clk);
  endtask : ins
  // One-cycle stop recovery pulse
  task rcv();
    stopRecovery <= 1'h1;
    @(posedge sys_clk) stopRecovery <= 1'h0;
    @(posedge sys_clk);
  endtask : rcv
  // Ticks on one oscillator pin, then checks fire count
  task step(input logic rc, input int n, input logic [7:0] f);
    logic [7:0] f0;
    f0 = fires;
    repeat (n) begin
      if (rc) rcOscPin <= 1'h1;
      else crystal_input_pin <= 1'h1;
      repeat (3) @(posedge sys_clk);
      rcOscPin <= 1'h0;
      crystal_input_pin <= 1'h0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
    chk(fires - f0, f);
  endtask : step
  task report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Hang guard
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end
  // ==========
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge sys_clk);
    rd(WMC_STATUS_ADDR, 8'h02);
    wr(WMC_MODE_ADDR, 8'hF0);
    rd(WMC_STATUS_ADDR, 8'h06);
    rd(WMC_MODE_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    ins();
    rd(WMC_STATUS_ADDR, 8'h07);
    step(1'h0, 100, 8'h00);
    haltMode <= 1'h1;
    step(1'h0, 300, 8'h00);
    haltMode <= 1'h0;
    rd(WMC_STATUS_ADDR, 8'h05);
    wr(WMC_MODE_ADDR, 8'h00);
    rd(WMC_STATUS_ADDR, 8'h05);
    step(1'h0, 155, 8'h00);
    step(1'h0, 1, 8'h01);
    rd(WMC_STATUS_ADDR, 8'h02);
    $display("crystal tap test done");
    ins();
    step(1'h1, 511, 8'h00);
    step(1'h1, 1, 8'h01);
    $display("default tap test done");
    wr(WMC_MODE_ADDR, 8'h18);
    ins();
    stopMode <= 1'h1;
    step(1'h1, 300, 8'h00);
    step(1'h0, 256, 8'h01);
    wr(WMC_MODE_ADDR, 8'h08);
    ins();
    step(1'h0, 300, 8'h00);
    step(1'h1, 256, 8'h01);
    $display("stop clock test done");
    wr(WMC_MODE_ADDR, 8'h14);
    ins();
    // RC is the stop clock here, so only suspension keeps it quiet
    step(1'h1, 300, 8'h00);
    stopMode <= 1'h0;
    haltMode <= 1'h1;
    step(1'h0, 256, 8'h01);
    haltMode <= 1'h0;
    $display("suspend test done");
    wr(WMC_MODE_ADDR, 8'h10);
    ins();
    low_voltage_trip_point <= 1'h1;
    repeat (8) @(posedge sys_clk);
    chk({7'h00, globalReset}, 8'h01);
    low_voltage_trip_point <= 1'h0;
    repeat (8) @(posedge sys_clk);
    chk({7'h00, globalReset}, 8'h00);
    rd(WMC_STATUS_ADDR, 8'h02);
    $display("low supply test done");
    // Window closes exactly on the 128th crystal tick
    step(1'h0, 127, 8'h00);
    rd(WMC_STATUS_ADDR, 8'h02);
    step(1'h0, 1, 8'h00);
    rd(WMC_STATUS_ADDR, 8'h00);
    wr(WMC_MODE_ADDR, 8'h10);
    rd(WMC_STATUS_ADDR, 8'h00);
    // Stop recovery reopens the window
    rcv();
    rd(WMC_STATUS_ADDR, 8'h02);
    wr(WMC_MODE_ADDR, 8'h10);
    rd(WMC_STATUS_ADDR, 8'h06);
    $display("write window test done");
    // Frozen block must not count ticks toward the window
    clkEn <= 1'h0;
    step(1'h0, 200, 8'h00);
    clkEn <= 1'h1;
    rd(WMC_STATUS_ADDR, 8'h06);
    $display("clock enable test done");
    report_and_stop();
  end
endmodule : test_watchdog_mode_clock_select
`default_nettype wire
